// File: delta_angle_velocity_integrator.v
// trapezoidal delta angle and delta velocity integrator with read-only word registers
`include "delta_integrator_map.vh"

// What this block does
// - velocity step sums current plus previous acceleration, scaled by one over twice rate.
// - angle step uses the same trapezoid sums on gyroscope rate samples.
// - each update sums decimation setting plus one input samples.
// - input samples are taken at 2000 samples per second from the internal clock.
// - each result covers only samples since the previous update; sums restart.
// - each result is one 32-bit two's complement word, upper and lower halves.
// - angle upper word zero is 0x0000, one bit is range over two to fifteen.
// - angle range is fixed per variant at 360, 720 or 2160 degrees.
// - velocity upper word spans plus or minus 400 m/sec, zero is 0x0000.
// - velocity lower word holds the extra low-order resolution bits.
// - angle words sit at 0x24 through 0x2E, lower word first per axis.
// - velocity words sit at 0x30 through 0x3A, lower word first per axis.
// - results saturate at 0x80000000 and 0x7FFFFFFF.
module delta_angle_velocity_integrator #(
  // sample and accumulator widths
  parameter SAMPLE_W = 16,
  parameter ACC_W = 48,
  // variant angle range and internal sample period in core clocks
  parameter [1:0] ANGLE_RANGE_SEL = `ANGLE_RANGE_360,
  parameter SAMPLE_CYCLES = `SAMPLE_PERIOD_CYCLES,
  // full-scale shift of the rate and acceleration inputs
  parameter [4:0] RATE_FS = 5'd16,
  parameter [4:0] ACCEL_FS = 5'd16
) (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // per-sample sensor values and decimation setting
  input wire [3*SAMPLE_W-1:0] gyro_rate_i,
  input wire [3*SAMPLE_W-1:0] accel_i,
  input wire [15:0] decimation_setting_i,
  // register access from the host side
  input wire [6:0] reg_addr_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // timing pulses
  output wire sample_strobe_o,
  output reg update_o
);

  // counter width follows the period, so a long period cannot wrap early
  localparam CNT_W = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
  localparam [31:0] SAMPLE_LAST_FULL = SAMPLE_CYCLES - 1;
  localparam [CNT_W-1:0] SAMPLE_LAST = SAMPLE_LAST_FULL[CNT_W-1:0];

  // number of result channels: three angle, then three velocity
  localparam CHAN_N = 6;
  localparam RES_W = 32;

  // clamp a wide sum into the 32-bit result range; keeps the sign
  function [31:0] sat32;
    input [ACC_W-1:0] v;
    reg neg;
    reg hi_ones;
    reg hi_any;
    begin
      neg = v[ACC_W-1];
      hi_ones = &v[ACC_W-2:31];
      hi_any = |v[ACC_W-2:31];
      if (neg && !hi_ones) begin
        sat32 = 32'h80000000;
      end else if (!neg && hi_any) begin
        sat32 = 32'h7FFFFFFF;
      end else begin
        sat32 = v[31:0];
      end
    end
  endfunction

  // select one 16-bit word of a result for the read mux
  function [15:0] word_of;
    input [31:0] w;
    input upper;
    begin
      if (upper) begin
        word_of = w[31:16];
      end else begin
        word_of = w[15:0];
      end
    end
  endfunction

  // sign-extend one sample to the accumulator width
  function [ACC_W-1:0] sign_ext;
    input [SAMPLE_W-1:0] s;
    begin
      sign_ext = {{(ACC_W-SAMPLE_W){s[SAMPLE_W-1]}}, s};
    end
  endfunction

  // output shift: angle channels use the rate scale, velocity the accel scale
  function [4:0] shift_of;
    input is_angle;
    begin
      if (is_angle) begin
        shift_of = 5'h1F - RATE_FS - 5'h0C;
      end else begin
        shift_of = 5'h1F - ACCEL_FS - 5'h0C;
      end
    end
  endfunction

  // map a byte address onto {hit, channel, upper}; bit0 is ignored, both bytes of a word share one slot
  function [4:0] addr_slot;
    input [6:0] a;
    begin
      case ({a[6:1], 1'b0})
        // angle x
        `ANGLE_STEP_X_LOWER: begin
          addr_slot = {1'h1, 3'h0, 1'h0};
        end
        `ANGLE_STEP_X_UPPER: begin
          addr_slot = {1'h1, 3'h0, 1'h1};
        end
        // angle y
        `ANGLE_STEP_Y_LOWER: begin
          addr_slot = {1'h1, 3'h1, 1'h0};
        end
        `ANGLE_STEP_Y_UPPER: begin
          addr_slot = {1'h1, 3'h1, 1'h1};
        end
        // angle z
        `ANGLE_STEP_Z_LOWER: begin
          addr_slot = {1'h1, 3'h2, 1'h0};
        end
        `ANGLE_STEP_Z_UPPER: begin
          addr_slot = {1'h1, 3'h2, 1'h1};
        end
        // velocity x
        `VELOCITY_STEP_X_LOWER: begin
          addr_slot = {1'h1, 3'h3, 1'h0};
        end
        `VELOCITY_STEP_X_UPPER: begin
          addr_slot = {1'h1, 3'h3, 1'h1};
        end
        // velocity y
        `VELOCITY_STEP_Y_LOWER: begin
          addr_slot = {1'h1, 3'h4, 1'h0};
        end
        `VELOCITY_STEP_Y_UPPER: begin
          addr_slot = {1'h1, 3'h4, 1'h1};
        end
        // velocity z
        `VELOCITY_STEP_Z_LOWER: begin
          addr_slot = {1'h1, 3'h5, 1'h0};
        end
        `VELOCITY_STEP_Z_UPPER: begin
          addr_slot = {1'h1, 3'h5, 1'h1};
        end
        // anything else misses and reads zero
        default: begin
          addr_slot = {1'h0, 3'h0, 1'h0};
        end
      endcase
    end
  endfunction

  // internal sample clock: one strobe per nominal 2000 SPS period
  reg [CNT_W-1:0] tick_r;
  wire [CNT_W-1:0] tick_nxt;
  wire tick_wrap;

  // wrap compare is shared by the strobe and the counter
  assign tick_wrap = (tick_r == SAMPLE_LAST);
  assign tick_nxt = tick_wrap ? {CNT_W{1'b0}} : tick_r + 1'b1;
  assign sample_strobe_o = tick_wrap;

  // free running; the period is the only timing reference of the integrator
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_r <= {CNT_W{1'b0}};
    end else begin
      tick_r <= tick_nxt;
    end
  end

  // decimation counter; setting is latched at each update so a change mid-interval is safe
  reg [15:0] dec_cnt_r;
  reg [15:0] dec_set_r;
  reg [15:0] dec_cnt_nxt;
  wire last_sample;

  // the interval closes on the strobe whose count equals the setting
  assign last_sample = sample_strobe_o && (dec_cnt_r == dec_set_r);

  // next count: restart after the last sample, step on every other strobe
  always @* begin
    dec_cnt_nxt = dec_cnt_r;
    if (last_sample) begin
      dec_cnt_nxt = 16'h0000;
    end else if (sample_strobe_o) begin
      dec_cnt_nxt = dec_cnt_r + 16'h0001;
    end
  end

  // count, setting and update pulse share one reset
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_cnt_r <= 16'h0000;
      dec_set_r <= 16'h0000;
      update_o <= 1'b0;
    end else begin
      dec_cnt_r <= dec_cnt_nxt;
      update_o <= last_sample;
      if (last_sample) begin
        dec_set_r <= decimation_setting_i;
      end
    end
  end

  // per-axis trapezoid accumulators; six channels share one generate body
  // inputs ordered x, y, z angle then x, y, z velocity to match the result slots
  wire [CHAN_N*SAMPLE_W-1:0] chan_in;
  wire [CHAN_N*RES_W-1:0] result_w;

  assign chan_in = {accel_i, gyro_rate_i};

  genvar g;
  generate
    for (g = 0; g < CHAN_N; g = g + 1) begin : chan
      reg signed [SAMPLE_W-1:0] prev_r;
      reg signed [ACC_W-1:0] acc_r;
      reg [RES_W-1:0] result_r;
      wire signed [SAMPLE_W-1:0] cur;
      wire signed [ACC_W-1:0] cur_ext;
      wire signed [ACC_W-1:0] prev_ext;
      wire signed [ACC_W-1:0] pair;
      wire signed [ACC_W-1:0] sum_nxt;
      wire [4:0] out_sh;
      wire signed [ACC_W-1:0] scaled;

      // widen both samples before the add so the pair cannot overflow
      assign cur = chan_in[g*SAMPLE_W +: SAMPLE_W];
      assign cur_ext = sign_ext(cur);
      assign prev_ext = sign_ext(prev_r);
      assign pair = cur_ext + prev_ext;
      assign sum_nxt = acc_r + pair;

      // pair sum is twice the mean; shift aligns to the 2^31 full-scale word
      // scale is fixed by the full-scale parameters, so 1/(2 fs) folds into the shift
      assign out_sh = shift_of(g < 3);
      assign scaled = sum_nxt <<< out_sh;

      // previous sample carries across updates, so the trapezoid has no seam
      always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          prev_r <= {SAMPLE_W{1'b0}};
          acc_r <= {ACC_W{1'b0}};
        end else if (sample_strobe_o) begin
          prev_r <= cur;
          if (last_sample) begin
            acc_r <= {ACC_W{1'b0}};
          end else begin
            acc_r <= sum_nxt;
          end
        end
      end

      // result word has no reset value and only the update writes it
      always @(posedge core_clk_i) begin
        if (last_sample) begin
          result_r <= sat32(scaled);
        end
      end

      assign result_w[g*RES_W +: RES_W] = result_r;
    end
  endgenerate

  // decoded slot of the current read address
  wire [4:0] rd_slot;
  wire rd_hit;
  wire [2:0] rd_chan;
  wire rd_upper;
  reg [31:0] rd_result;

  assign rd_slot = addr_slot(reg_addr_i);
  assign rd_hit = rd_slot[4];
  assign rd_chan = rd_slot[3:1];
  assign rd_upper = rd_slot[0];

  // pick the addressed result; each half is read on its own, so an update between two reads can mix loads
  always @* begin
    rd_result = 32'h00000000;
    case (rd_chan)
      // angle x
      3'h0: begin
        rd_result = result_w[0*RES_W +: RES_W];
      end
      // angle y
      3'h1: begin
        rd_result = result_w[1*RES_W +: RES_W];
      end
      // angle z
      3'h2: begin
        rd_result = result_w[2*RES_W +: RES_W];
      end
      // velocity x
      3'h3: begin
        rd_result = result_w[3*RES_W +: RES_W];
      end
      // velocity y
      3'h4: begin
        rd_result = result_w[4*RES_W +: RES_W];
      end
      // velocity z
      3'h5: begin
        rd_result = result_w[5*RES_W +: RES_W];
      end
      default: begin
        rd_result = 32'h00000000;
      end
    endcase
  end

  // registered read data; unmapped addresses read zero and writes never reach it
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (rd_hit) begin
        reg_rdata_o <= word_of(rd_result, rd_upper);
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // write port has no effect here; range select only documents the angle scale
  wire unused_ok = reg_wr_i | (|reg_wdata_i) | (|ANGLE_RANGE_SEL);

endmodule // delta_angle_velocity_integrator

// File: delta_angle_velocity_integrator_bench.sv
// self-checking bench for the delta angle and velocity integrator
module delta_angle_velocity_integrator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, resetn_i = 0;
  logic [47:0] gyro_rate_i = {16'h0100, 16'hFFFE, 16'h0001}, accel_i = {16'h0005, 16'h8000, 16'h7FFF};
  logic [15:0] decimation_setting_i = 16'h0001, d, dec_tab[3] = '{16'h0001, 16'h0000, 16'h0003};
  wire [6:0] reg_addr_i;
  wire reg_rd_i, reg_wr_i, sample_strobe_o, update_o;
  wire [15:0] reg_wdata_i, reg_rdata_o;
  logic signed [15:0] s;
  int errors = 0, comparisons = 0, v;
  always #25 core_clk_i = ~core_clk_i;
  delta_angle_velocity_integrator #(.SAMPLE_CYCLES(10)) u_delta_angle_velocity_integrator (.core_clk_i, .resetn_i,
    .gyro_rate_i, .accel_i, .decimation_setting_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .sample_strobe_o, .update_o);
  host_reader_model u_host_reader_model (.core_clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .rd_o(reg_rd_i),
    .wr_o(reg_wr_i), .wdata_o(reg_wdata_i));
  task check(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait; a missing update ends the run
  task wait_update(input int lim);
    int n;
    for (n = 0; n < lim && update_o !== 1'b1; n++) @(negedge core_clk_i);
    if (n == lim) begin
      errors++;
      end_of_test();
    end else begin
      @(negedge core_clk_i);
    end
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    check(reg_rdata_o, 16'h0000);
    check({15'h0000, update_o}, 16'h0000);
    resetn_i = 1;
    // setting takes effect one interval late, so let three updates pass
    foreach (dec_tab[k]) begin
      decimation_setting_i = dec_tab[k];
      repeat (3) wait_update(400);
      for (int i = 0; i < 14; i++) begin
        s = i < 6 ? gyro_rate_i[16*(i/2)+:16] : accel_i[16*(i/2-3)+:16];
        v = i < 12 ? int'(s) * 16 * (int'(dec_tab[k]) + 1) : 0;
        u_host_reader_model.read_word(i < 12 ? 7'(7'h24 + 2 * i) : (i == 12 ? 7'h10 : 7'h41), d);
        check(d, i[0] ? v[31:16] : v[15:0]);
      end
    end
    // a 4097-sample interval drives the x and y velocity sums past the 32-bit range
    decimation_setting_i = 16'h1000;
    wait_update(400);
    wait_update(42000);
    for (int i = 6; i < 10; i++) begin
      u_host_reader_model.read_word(7'(7'h24 + 2 * i), d);
      check(d, i < 8 ? (i[0] ? 16'h7FFF : 16'hFFFF) : (i[0] ? 16'h8000 : 16'h0000));
    end
    // write to a result word must not stick
    u_host_reader_model.write_word(7'h32, 16'h1234);
    u_host_reader_model.read_word(7'h32, d);
    check(d, 16'h7FFF);
    end_of_test();
  end
endmodule // delta_angle_velocity_integrator_bench
bind delta_angle_velocity_integrator delta_integrator_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_delta_integrator_checker (
  .core_clk_i, .resetn_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_rdata_o, .sample_strobe_o, .update_o);

// File: delta_integrator_checker.sv
// port-level assertions for the delta angle and velocity integrator
module delta_integrator_checker #(parameter SAMPLE_CYCLES = 10) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [6:0] reg_addr_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [15:0] reg_rdata_o,
  input wire sample_strobe_o,
  input wire update_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] gap_r;
  logic seen_r;
  // cycles since last strobe; first gap after reset is not judged
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= sample_strobe_o ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | sample_strobe_o;
    end
  end
  a_strobe_period: assert property (sample_strobe_o && seen_r |-> gap_r == SAMPLE_CYCLES - 1)
    else $error("sample strobe spacing wrong");
  a_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe longer than one cycle");
  a_update_after_strobe: assert property (update_o |-> $past(sample_strobe_o))
    else $error("update without preceding sample");
  a_update_spacing: assert property (update_o |=> !update_o [*8])
    else $error("updates too close together");
  a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 7'h24 || reg_addr_i > 7'h3B) |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_write_ignored: assert property (reg_wr_i && !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("write disturbed read data");
  a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_update_no_rdata: assert property (update_o && !$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("result load changed read data");
endmodule // delta_integrator_checker

// File: delta_integrator_map.vh
// register offsets, scale and timing constants for the delta angle and velocity integrator
`ifndef DELTA_INTEGRATOR_MAP_VH
`define DELTA_INTEGRATOR_MAP_VH
`define ANGLE_STEP_X_LOWER 7'h24
`define ANGLE_STEP_X_UPPER 7'h26
`define ANGLE_STEP_Y_LOWER 7'h28
`define ANGLE_STEP_Y_UPPER 7'h2A
`define ANGLE_STEP_Z_LOWER 7'h2C
`define ANGLE_STEP_Z_UPPER 7'h2E
`define VELOCITY_STEP_X_LOWER 7'h30
`define VELOCITY_STEP_X_UPPER 7'h32
`define VELOCITY_STEP_Y_LOWER 7'h34
`define VELOCITY_STEP_Y_UPPER 7'h36
`define VELOCITY_STEP_Z_LOWER 7'h38
`define VELOCITY_STEP_Z_UPPER 7'h3A
`define SAMPLE_RATE_SPS 2000
`define CORE_CLK_HZ 20000000
`define SAMPLE_PERIOD_CYCLES (`CORE_CLK_HZ / `SAMPLE_RATE_SPS)
`define ANGLE_RANGE_360 2'h0
`define ANGLE_RANGE_720 2'h1
`define ANGLE_RANGE_2160 2'h2
`define VELOCITY_RANGE_MPS 400
`endif

// File: host_reader_model.sv
// host side model issuing single-word register reads and writes
module host_reader_model (
  input wire core_clk_i,
  input wire [15:0] rdata_i,
  output logic [6:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 7'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // strobe held one full cycle; results used at nominal rate, no rescale
  task read_word(input logic [6:0] a, output logic [15:0] d);
    @(negedge core_clk_i) {addr_o, rd_o} = {a, 1'b1};
    @(negedge core_clk_i) {addr_o, rd_o} = {~a, 1'b0};
    d = rdata_i;
  endtask
  task write_word(input logic [6:0] a, input logic [15:0] w);
    @(negedge core_clk_i) {addr_o, wr_o, wdata_o} = {a, 1'b1, w};
    @(negedge core_clk_i) {addr_o, wr_o, wdata_o} = {~a, 1'b0, ~w};
  endtask
endmodule // host_reader_model
